// ==== sacc_pkg.sv ====
// Package with register map, field positions and timing counts of the converter control.
package sacc_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] SACC_OFF_CTRL = 8'h00;
    localparam logic [7:0] SACC_OFF_RESULT_HIGH = 8'h04;
    localparam logic [7:0] SACC_OFF_MODE = 8'h08;
    localparam logic [7:0] SACC_OFF_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] SACC_OFF_IRQ_CLEAR = 8'h10;
    localparam logic [7:0] SACC_OFF_IRQ_ENABLE = 8'h14;

    // ****************************************
    // Control, mode and interrupt register fields
    // ****************************************
    localparam int SACC_BIT_RES1 = 7;
    localparam int SACC_BIT_RES0 = 6;
    localparam int SACC_BIT_EXT_EN = 5;
    localparam int SACC_BIT_DONE = 4;
    localparam int SACC_BIT_START = 3;
    localparam int SACC_CHAN_MSB = 2;
    localparam int SACC_BIT_IDLE = 0;
    localparam int SACC_BIT_PDOWN = 1;
    localparam int SACC_IRQ_DONE = 0;
    localparam int SACC_IRQ_ABORT = 1;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] SACC_CTRL_RESET = 8'h00;
    localparam logic [9:0] SACC_SAR_RESET = 10'h000;
    localparam logic [1:0] SACC_IRQ_RESET = 2'h0;

    // ****************************************
    // Timing
    // ****************************************
    localparam int SACC_CLK_HZ = 40_000_000;
    localparam int SACC_MC_NS = 1000;
    localparam logic [5:0] SACC_MC_CYCLES = 6'((SACC_MC_NS * (SACC_CLK_HZ / 1_000_000)) / 1000);
    localparam logic [5:0] SACC_TOTAL_MC = 6'h32;
    localparam logic [5:0] SACC_INIT_MC = 6'h02;
    localparam logic [5:0] SACC_SAMPLE_MC = 6'h08;
    localparam logic [5:0] SACC_BIT_MC = 6'h04;
    localparam logic [3:0] SACC_BITS = 4'hA;

    typedef enum logic [3:0] {
        SACC_IDLE = 4'h1,
        SACC_INIT = 4'h2,
        SACC_SAMPLE = 4'h4,
        SACC_TRIAL = 4'h8
    } sacc_state_t;

endpackage

// ==== sacc_step_if.sv ====
// Interface carrying the machine-cycle tick between the divider and the sequencer.
`timescale 1ns/1ps
`default_nettype none
interface sacc_step_if;
    logic tick;
    modport src (output tick);
    modport dst (input tick);
endinterface
`default_nettype wire

// ==== sacc_mc_div.sv ====
// Machine-cycle divider producing a one-cycle enable pulse at the end of each machine cycle.
`timescale 1ns/1ps
`default_nettype none
module sacc_mc_div
    import sacc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    sacc_step_if.src step
);
    logic [5:0] cnt_reg;
    logic [5:0] cnt_next;
    logic tick_reg;
    logic tick_next;

    always_comb begin
        cnt_next = cnt_reg + 6'h01;
        tick_next = 1'b0;
        if (cnt_reg == SACC_MC_CYCLES - 6'h01) begin
            cnt_next = 6'h00;
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= 6'h00;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign step.tick = tick_reg;
endmodule
`default_nettype wire

// ==== sacc_top.sv ====
// Conversion control of an eight-channel 10-bit successive-approximation converter.
`timescale 1ns/1ps
`default_nettype none
module sacc_top
    import sacc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic external_start_pin_i,
    input wire logic compare_high_i,
    output logic [2:0] analog_input_port_sel_o,
    output logic [9:0] trial_code_o,
    output logic sample_o,
    output logic irq_o
);
    // ****************************************
    // Machine-cycle divider
    // ****************************************
    sacc_step_if step ();
    sacc_mc_div u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .step(step)
    );

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic pin_s1_reg;
    logic pin_s2_reg;
    logic cmp_s1_reg;
    logic cmp_s2_reg;
    logic pin_low_seen_reg;
    logic pin_low_seen_next;
    logic pin_prev_reg;
    logic pin_prev_next;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1_reg <= 1'b0;
            pin_s2_reg <= 1'b0;
            cmp_s1_reg <= 1'b0;
            cmp_s2_reg <= 1'b0;
        end else begin
            pin_s1_reg <= external_start_pin_i;
            pin_s2_reg <= pin_s1_reg;
            cmp_s1_reg <= compare_high_i;
            cmp_s2_reg <= cmp_s1_reg;
        end
    end

    // ****************************************
    // Register state
    // ****************************************
    logic [2:0] chan_reg;
    logic [2:0] chan_next;
    logic ext_en_reg;
    logic ext_en_next;
    logic done_reg;
    logic done_next;
    logic cmd_reg;
    logic cmd_next;
    logic busy_reg;
    logic busy_next;
    logic [9:0] result_reg;
    logic [9:0] result_next;
    logic [1:0] pmode_reg;
    logic [1:0] pmode_next;
    logic [1:0] irq_stat_reg;
    logic [1:0] irq_stat_next;
    logic [1:0] irq_en_reg;
    logic [1:0] irq_en_next;
    logic [31:0] dat_reg;
    logic [31:0] dat_next;
    logic ack_reg;
    logic ack_next;
    sacc_state_t state_reg;
    sacc_state_t state_next;
    logic [5:0] mc_reg;
    logic [5:0] mc_next;
    logic [9:0] sar_reg;
    logic [9:0] sar_next;
    logic [3:0] bitp_reg;
    logic [3:0] bitp_next;
    logic [1:0] sub_reg;
    logic [1:0] sub_next;
    logic sample_reg;
    logic sample_next;
    logic irq_reg;
    logic irq_next;

    function automatic logic [9:0] sacc_onehot(input logic [3:0] idx);
        sacc_onehot = 10'h001 << idx;
    endfunction

    logic bus_req;
    logic wr_ctrl;
    logic sw_start;
    logic ext_start;
    logic blocked;
    logic stop_req;
    logic done_evt;
    logic abort_evt;

    always_comb begin
        bus_req = cyc_i && stb_i && !ack_reg;
        wr_ctrl = bus_req && we_i && sel_i[0] && adr_i == SACC_OFF_CTRL;
        blocked = busy_reg || done_reg || cmd_reg;
        sw_start = wr_ctrl && dat_i[SACC_BIT_START];
        ext_start = ext_en_reg && step.tick && pin_s2_reg && !pin_prev_reg && pin_low_seen_reg;
        stop_req = pmode_reg != 2'h0;
        done_evt = 1'b0;
        abort_evt = 1'b0;

        pin_prev_next = pin_prev_reg;
        pin_low_seen_next = pin_low_seen_reg;
        if (step.tick) begin
            pin_prev_next = pin_s2_reg;
            pin_low_seen_next = !pin_s2_reg || (pin_low_seen_reg && pin_prev_reg == 1'b0
                && !pin_s2_reg);
        end

        chan_next = chan_reg;
        ext_en_next = ext_en_reg;
        done_next = done_reg;
        cmd_next = cmd_reg;
        busy_next = busy_reg;
        result_next = result_reg;
        pmode_next = pmode_reg;
        irq_en_next = irq_en_reg;
        state_next = state_reg;
        mc_next = mc_reg;
        sar_next = sar_reg;
        bitp_next = bitp_reg;
        sub_next = sub_reg;
        sample_next = sample_reg;

        if (wr_ctrl) begin
            chan_next = dat_i[SACC_CHAN_MSB:0];
            ext_en_next = dat_i[SACC_BIT_EXT_EN];
            if (!dat_i[SACC_BIT_DONE]) begin
                done_next = 1'b0;
            end
        end
        if ((sw_start || ext_start) && !blocked && !stop_req) begin
            cmd_next = 1'b1;
        end
        if (bus_req && we_i && sel_i[0] && adr_i == SACC_OFF_MODE) begin
            pmode_next = dat_i[1:0];
        end
        if (bus_req && we_i && sel_i[0] && adr_i == SACC_OFF_IRQ_ENABLE) begin
            irq_en_next = dat_i[1:0];
        end

        if (stop_req && (state_reg != SACC_IDLE || cmd_reg)) begin
            state_next = SACC_IDLE;
            busy_next = 1'b0;
            cmd_next = 1'b0;
            sample_next = 1'b0;
            abort_evt = 1'b1;
            if (pmode_reg[SACC_BIT_PDOWN]) begin
                done_next = 1'b0;
            end
        end else if (step.tick) begin
            mc_next = mc_reg + 6'h01;
            case (state_reg)
                SACC_IDLE: begin
                    mc_next = 6'h00;
                    if (cmd_reg) begin
                        state_next = SACC_INIT;
                        mc_next = 6'h01;
                    end
                end
                SACC_INIT: begin
                    busy_next = 1'b1;
                    if (mc_reg == SACC_INIT_MC) begin
                        state_next = SACC_SAMPLE;
                        sample_next = 1'b1;
                    end
                end
                SACC_SAMPLE: begin
                    if (mc_reg == SACC_INIT_MC + SACC_SAMPLE_MC) begin
                        state_next = SACC_TRIAL;
                        sample_next = 1'b0;
                        bitp_next = SACC_BITS - 4'h1;
                        sub_next = 2'h0;
                        sar_next = sacc_onehot(SACC_BITS - 4'h1);
                    end
                end
                SACC_TRIAL: begin
                    sub_next = sub_reg + 2'h1;
                    if (sub_reg == 2'(SACC_BIT_MC - 6'h01) && bitp_reg != 4'h0) begin
                        if (!cmp_s2_reg) begin
                            sar_next = sar_reg & ~sacc_onehot(bitp_reg);
                        end
                        sar_next = sar_next | sacc_onehot(bitp_reg - 4'h1);
                        bitp_next = bitp_reg - 4'h1;
                    end else if (sub_reg == 2'(SACC_BIT_MC - 6'h01) && !cmp_s2_reg) begin
                        sar_next = sar_reg & ~sacc_onehot(4'h0);
                    end
                    if (mc_reg == SACC_TOTAL_MC) begin
                        state_next = SACC_IDLE;
                        busy_next = 1'b0;
                        cmd_next = 1'b0;
                        done_next = 1'b1;
                        done_evt = 1'b1;
                        if (!done_reg) begin
                            result_next = sar_next;
                        end
                    end
                end
                default: begin
                    state_next = SACC_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Interrupts and bus answer
    // ****************************************
    always_comb begin
        irq_stat_next = irq_stat_reg;
        if (bus_req && we_i && sel_i[0] && adr_i == SACC_OFF_IRQ_CLEAR) begin
            irq_stat_next = irq_stat_reg & ~dat_i[1:0];
        end
        if (done_evt) begin
            irq_stat_next[SACC_IRQ_DONE] = 1'b1;
        end
        if (abort_evt) begin
            irq_stat_next[SACC_IRQ_ABORT] = 1'b1;
        end
        irq_next = |(irq_stat_reg & irq_en_reg);
        ack_next = bus_req;
        dat_next = 32'h0000_0000;
        if (bus_req && !we_i) begin
            case (adr_i)
                SACC_OFF_CTRL: dat_next[7:0] = {result_reg[1:0], ext_en_reg, done_reg,
                    busy_reg, chan_reg};
                SACC_OFF_RESULT_HIGH: dat_next[7:0] = result_reg[9:2];
                SACC_OFF_MODE: dat_next[1:0] = pmode_reg;
                SACC_OFF_IRQ_STATUS: dat_next[1:0] = irq_stat_reg;
                SACC_OFF_IRQ_ENABLE: dat_next[1:0] = irq_en_reg;
                default: dat_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chan_reg <= SACC_CTRL_RESET[2:0];
            ext_en_reg <= 1'b0;
            done_reg <= 1'b0;
            cmd_reg <= 1'b0;
            busy_reg <= 1'b0;
            result_reg <= SACC_SAR_RESET;
            pmode_reg <= 2'h0;
            irq_stat_reg <= SACC_IRQ_RESET;
            irq_en_reg <= SACC_IRQ_RESET;
            dat_reg <= 32'h0000_0000;
            ack_reg <= 1'b0;
            state_reg <= SACC_IDLE;
            mc_reg <= 6'h00;
            sar_reg <= SACC_SAR_RESET;
            bitp_reg <= 4'h0;
            sub_reg <= 2'h0;
            sample_reg <= 1'b0;
            irq_reg <= 1'b0;
            pin_prev_reg <= 1'b1;
            pin_low_seen_reg <= 1'b0;
        end else begin
            chan_reg <= chan_next;
            ext_en_reg <= ext_en_next;
            done_reg <= done_next;
            cmd_reg <= cmd_next;
            busy_reg <= busy_next;
            result_reg <= result_next;
            pmode_reg <= pmode_next;
            irq_stat_reg <= irq_stat_next;
            irq_en_reg <= irq_en_next;
            dat_reg <= dat_next;
            ack_reg <= ack_next;
            state_reg <= state_next;
            mc_reg <= mc_next;
            sar_reg <= sar_next;
            bitp_reg <= bitp_next;
            sub_reg <= sub_next;
            sample_reg <= sample_next;
            irq_reg <= irq_next;
            pin_prev_reg <= pin_prev_next;
            pin_low_seen_reg <= pin_low_seen_next;
        end
    end

    assign dat_o = dat_reg;
    assign ack_o = ack_reg;
    assign analog_input_port_sel_o = chan_reg;
    assign trial_code_o = sar_reg;
    assign sample_o = sample_reg;
    assign irq_o = irq_reg;
endmodule
`default_nettype wire

// ==== sacc_top_asserts.sv ====
// Checker with concurrent assertions on the ports of the converter control.
`timescale 1ns/1ps
`default_nettype none
module sacc_top_asserts
    import sacc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic [9:0] trial_code_o,
    input wire logic sample_o,
    input wire logic irq_o
);
    // ****************************************
    // Helper logic and properties
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [9:0] samp_cnt_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i || !sample_o) begin
            samp_cnt_reg <= 10'h000;
        end else begin
            samp_cnt_reg <= samp_cnt_reg + 10'h001;
        end
    end
    a_ack_single_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    a_ack_answers_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered in one cycle");
    a_ack_needs_req: assert property (!(cyc_i && stb_i) |=> !ack_o)
        else $error("ack without a request");
    a_dat_idle_zero: assert property (!ack_o |-> dat_o == 32'h0000_0000)
        else $error("read data not zero outside ack");
    a_dat_upper_zero: assert property (dat_o[31:8] == 24'h00_0000)
        else $error("upper read data bits not zero");
    a_reset_clears_out: assert property ($fell(rst_i)
        |-> !ack_o && !irq_o && trial_code_o == 10'h000)
        else $error("outputs not cleared by reset");
    a_sample_eight_mc: assert property ($fell(sample_o) |-> samp_cnt_reg == 10'h140)
        else $error("sampling phase not eight machine cycles");
    a_first_trial_msb: assert property ($fell(sample_o)
        |-> ##[0:40] trial_code_o == 10'h200)
        else $error("first trial is not the top bit alone");
    a_code_steady_sample: assert property (sample_o && $past(sample_o)
        |-> $stable(trial_code_o))
        else $error("trial code moved during sampling");
    c_sample_done: cover property ($fell(sample_o));
    c_irq_seen: cover property ($rose(irq_o));
    c_read_data: cover property (ack_o && dat_o != 32'h0000_0000);
endmodule
bind sacc_top sacc_top_asserts chk_i (.clk_i, .rst_i, .cyc_i, .stb_i, .dat_o, .ack_o,
    .trial_code_o, .sample_o, .irq_o);
`default_nettype wire

// ==== sacc_top_bench.sv ====
// Self-checking testbench of the converter control.
`timescale 1ns/1ps
`default_nettype none
module sacc_top_bench
    import sacc_pkg::*;
();
    logic clk_i, rst_i, cyc_i, stb_i, we_i, pin, cmp, irq_o, ack_o, sample_o;
    logic [7:0] adr_i, q;
    logic [31:0] dat_i, dat_o;
    logic [2:0] sel_o;
    logic [9:0] code, target, e;
    int fails, checked, cycles;
    time t0, t1;
    sacc_top uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .external_start_pin_i(pin), .compare_high_i(cmp), .analog_input_port_sel_o(sel_o),
        .trial_code_o(code), .sample_o(sample_o), .irq_o(irq_o));
    // ****************************************
    // Clock, comparator and bus tasks
    // ****************************************
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cmp <= (target > code);
        cycles++;
        if (cycles > 20000) begin
            fails++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("fails %0d checked %0d", fails, checked);
        if (fails == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [9:0] g, input logic [9:0] x);
        checked++;
        if (g !== x) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h00_0000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        q = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        chk(10'(n), 10'h002);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        wb(1'b0, a, 8'h00);
        chk({2'h0, q}, {2'h0, x});
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wait_irq();
        int n;
        n = 0;
        while (irq_o !== 1'b1 && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
        t1 = $time;
        chk({9'h000, irq_o}, 10'h001);
    endtask
    function automatic logic [9:0] sar(input logic [9:0] t);
        logic [9:0] r;
        r = 10'h000;
        for (int b = 9; b >= 0; b--) begin
            if (t > (r | (10'h001 << b))) begin
                r = r | (10'h001 << b);
            end
        end
        return r;
    endfunction
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_soft();
        rd(8'h3C, 8'h00);
        rd(SACC_OFF_CTRL, 8'h00);
        target = 10'h2C5;
        e = sar(target);
        wb(1'b1, SACC_OFF_IRQ_ENABLE, 8'h01);
        wb(1'b1, SACC_OFF_CTRL, 8'h05);
        chk({7'h00, sel_o}, 10'h005);
        wb(1'b1, SACC_OFF_CTRL, 8'h0D);
        t0 = $time;
        idle(200);
        wb(1'b1, SACC_OFF_CTRL, 8'h05);
        rd(SACC_OFF_CTRL, 8'h0D);
        wait_irq();
        chk(10'(((t1 - t0) / 25) >= 1960 && ((t1 - t0) / 25) <= 2045), 10'h001);
        rd(SACC_OFF_RESULT_HIGH, e[9:2]);
        rd(SACC_OFF_CTRL, {e[1:0], 6'h15});
    endtask
    task automatic t_blocked();
        target = 10'h0FF;
        wb(1'b1, SACC_OFF_CTRL, 8'h1D);
        idle(100);
        rd(SACC_OFF_CTRL, {e[1:0], 6'h15});
        rd(SACC_OFF_RESULT_HIGH, e[9:2]);
        wb(1'b1, SACC_OFF_CTRL, 8'hD5);
        rd(SACC_OFF_CTRL, {e[1:0], 6'h15});
        rd(SACC_OFF_IRQ_STATUS, 8'h01);
        wb(1'b1, SACC_OFF_IRQ_ENABLE, 8'h00);
        idle(3);
        chk({9'h000, irq_o}, 10'h000);
        wb(1'b1, SACC_OFF_IRQ_CLEAR, 8'h01);
        rd(SACC_OFF_IRQ_STATUS, 8'h00);
        wb(1'b1, SACC_OFF_IRQ_ENABLE, 8'h01);
        wb(1'b1, SACC_OFF_CTRL, 8'h05);
        wb(1'b1, SACC_OFF_CTRL, 8'h15);
        rd(SACC_OFF_CTRL, {e[1:0], 6'h05});
    endtask
    task automatic t_ext();
        target = 10'h155;
        pin <= 1'b1;
        idle(100);
        pin <= 1'b0;
        idle(100);
        pin <= 1'b1;
        idle(200);
        rd(SACC_OFF_CTRL, {e[1:0], 6'h05});
        pin <= 1'b0;
        wb(1'b1, SACC_OFF_CTRL, 8'h25);
        idle(100);
        pin <= 1'b1;
        idle(250);
        rd(SACC_OFF_CTRL, {e[1:0], 6'h2D});
        wait_irq();
        e = sar(target);
        rd(SACC_OFF_RESULT_HIGH, e[9:2]);
        wb(1'b1, SACC_OFF_MODE, 8'h01);
        rd(SACC_OFF_CTRL, {e[1:0], 6'h35});
        wb(1'b1, SACC_OFF_MODE, 8'h00);
    endtask
    task automatic t_abort();
        for (int m = 1; m <= 2; m++) begin
            wb(1'b1, SACC_OFF_CTRL, 8'h05);
            wb(1'b1, SACC_OFF_IRQ_CLEAR, 8'h03);
            wb(1'b1, SACC_OFF_CTRL, 8'h0D);
            idle(600);
            wb(1'b1, SACC_OFF_MODE, 8'(m));
            idle(10);
            rd(SACC_OFF_CTRL, {e[1:0], 6'h05});
            rd(SACC_OFF_IRQ_STATUS, 8'h02);
            wb(1'b1, SACC_OFF_MODE, 8'h00);
        end
    endtask
    initial begin
        rst_i = 1'b1;
        {cyc_i, stb_i, we_i, pin} = 4'h0;
        adr_i = 8'h00;
        dat_i = 32'h0000_0000;
        target = 10'h000;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_soft();
        t_blocked();
        t_ext();
        t_abort();
        give_verdict();
    end
endmodule
`default_nettype wire
